// ### core/cca_top.sv
`timescale 1ns/1ns
`default_nettype none
module cca_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_cpu_idle,
    input wire logic i_timer0_ovf,
    input wire logic [2:0] i_port_in,
    input wire logic [2:0] i_gpio_out,
    input wire logic [2:0] i_gpio_oe,
    output logic [2:0] o_port_out,
    output logic [2:0] o_port_oe,
    output logic o_irq
);

    // ****************************************
    // bus handshake
    // ****************************************
    cca_pkg::cca_bus_e bus_r;
    cca_pkg::cca_bus_e bus_nxt;
    logic req;
    logic wr_fire;
    logic [31:0] rdata_r;
    logic [7:0] rbyte;

    assign req = i_avs_read | i_avs_write;

    always_comb begin
        bus_nxt = bus_r;
        case (bus_r)
            cca_pkg::CCA_BUS_IDLE: begin
                if (req) begin
                    bus_nxt = cca_pkg::CCA_BUS_ACK;
                end
            end
            cca_pkg::CCA_BUS_ACK: begin
                bus_nxt = cca_pkg::CCA_BUS_IDLE;
            end
            default: begin
                bus_nxt = cca_pkg::CCA_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus_r <= cca_pkg::CCA_BUS_IDLE;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // one wait cycle so read data comes from a flip-flop
    assign o_avs_waitrequest = req & (bus_r != cca_pkg::CCA_BUS_ACK);
    assign wr_fire = i_avs_write & (bus_r == cca_pkg::CCA_BUS_ACK);

    function automatic logic wr_hit(input logic fire, input logic [5:0] addr,
                                    input logic be0, input logic [5:0] off);
        wr_hit = fire & be0 & (addr == off);
    endfunction

    logic wr_mode;
    logic wr_ctrl;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_m0;
    logic wr_m1;
    logic wr_c0_lo;
    logic wr_c0_hi;
    logic wr_c1_lo;
    logic wr_c1_hi;
    logic [7:0] wbyte;

    assign wbyte = i_avs_writedata[7:0];
    assign wr_mode = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0], cca_pkg::CCA_OFF_MODE);
    assign wr_ctrl = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0], cca_pkg::CCA_OFF_CTRL);
    assign wr_cnt_lo = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                              cca_pkg::CCA_OFF_CNT_LO);
    assign wr_cnt_hi = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                              cca_pkg::CCA_OFF_CNT_HI);
    assign wr_m0 = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                          cca_pkg::CCA_OFF_MOD0_MODE);
    assign wr_m1 = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                          cca_pkg::CCA_OFF_MOD1_MODE);
    assign wr_c0_lo = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                             cca_pkg::CCA_OFF_CMP0_LO);
    assign wr_c0_hi = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                             cca_pkg::CCA_OFF_CMP0_HI);
    assign wr_c1_lo = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                             cca_pkg::CCA_OFF_CMP1_LO);
    assign wr_c1_hi = wr_hit(wr_fire, i_avs_address, i_avs_byteenable[0],
                             cca_pkg::CCA_OFF_CMP1_HI);

    // ****************************************
    // mode and control registers
    // ****************************************
    logic idle_stop_r;
    logic [1:0] src_r;
    logic ovf_irq_en_r;
    logic run_r;
    logic ovf_flag_r;
    logic [1:0] mod_flag_r;
    cca_pkg::cca_mode_s mode0_r;
    cca_pkg::cca_mode_s mode1_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            idle_stop_r <= 1'b0;
            src_r <= cca_pkg::CCA_SRC_DIV6;
            ovf_irq_en_r <= 1'b0;
        end else if (wr_mode) begin
            idle_stop_r <= wbyte[cca_pkg::CCA_MODE_IDLE_STOP];
            src_r <= wbyte[cca_pkg::CCA_MODE_SRC_HI:cca_pkg::CCA_MODE_SRC_LO];
            ovf_irq_en_r <= wbyte[cca_pkg::CCA_MODE_OVF_IRQ_EN];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode0_r <= cca_pkg::CCA_RST_MODE;
            mode1_r <= cca_pkg::CCA_RST_MODE;
        end else begin
            if (wr_m0) begin
                mode0_r <= cca_pkg::cca_mode_s'({1'b0, wbyte[6:0]});
            end
            if (wr_m1) begin
                mode1_r <= cca_pkg::cca_mode_s'({1'b0, wbyte[6:0]});
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            run_r <= 1'b0;
        end else if (wr_ctrl) begin
            run_r <= wbyte[cca_pkg::CCA_CTRL_RUN];
        end
    end

    // ****************************************
    // count source selection
    // ****************************************
    logic [2:0] div6_r;
    logic div2_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_prev_r;
    logic ext_rise;
    logic tick;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            div6_r <= 3'h0;
            div2_r <= 1'b0;
        end else begin
            div6_r <= (div6_r == cca_pkg::CCA_DIV6_LAST) ? 3'h0 : div6_r + 3'h1;
            div2_r <= ~div2_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_s1_r <= i_port_in[0];
            ext_s2_r <= ext_s1_r;
            ext_prev_r <= ext_s2_r;
        end
    end

    // pin must toggle below half the clock to be counted reliably
    assign ext_rise = ext_s2_r & ~ext_prev_r;

    always_comb begin
        case (src_r)
            cca_pkg::CCA_SRC_DIV6: tick = (div6_r == cca_pkg::CCA_DIV6_LAST);
            cca_pkg::CCA_SRC_DIV2: tick = div2_r;
            cca_pkg::CCA_SRC_T0OVF: tick = i_timer0_ovf;
            default: tick = ext_rise;
        endcase
    end

    // ****************************************
    // shared time base
    // ****************************************
    logic [15:0] count_r;
    logic step_r;
    logic advance;
    logic rollover;

    assign advance = tick & run_r & ~(idle_stop_r & i_cpu_idle);
    assign rollover = advance & ~(wr_cnt_lo | wr_cnt_hi) & (count_r == cca_pkg::CCA_CNT_TOP);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_r <= cca_pkg::CCA_RST_WORD;
        end else if (wr_cnt_lo | wr_cnt_hi) begin
            if (wr_cnt_lo) begin
                count_r[7:0] <= wbyte;
            end
            if (wr_cnt_hi) begin
                count_r[15:8] <= wbyte;
            end
        end else if (advance) begin
            count_r <= count_r + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            step_r <= 1'b0;
        end else begin
            step_r <= advance & ~(wr_cnt_lo | wr_cnt_hi);
        end
    end

    // ****************************************
    // compare / capture modules
    // ****************************************
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic ev0;
    logic ev1;
    logic pin0_out;
    logic pin1_out;

    cca_module u_mod0 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_mode(mode0_r),
        .i_count(count_r),
        .i_cnt_step(step_r),
        .i_pin_in(i_port_in[1]),
        .i_cmp_wr_lo(wr_c0_lo),
        .i_cmp_wr_hi(wr_c0_hi),
        .i_wdata(wbyte),
        .o_cmp(cmp0),
        .o_event(ev0),
        .o_pin_out(pin0_out)
    );

    cca_module u_mod1 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_mode(mode1_r),
        .i_count(count_r),
        .i_cnt_step(step_r),
        .i_pin_in(i_port_in[2]),
        .i_cmp_wr_lo(wr_c1_lo),
        .i_cmp_wr_hi(wr_c1_hi),
        .i_wdata(wbyte),
        .o_cmp(cmp1),
        .o_event(ev1),
        .o_pin_out(pin1_out)
    );

    // ****************************************
    // flags, hardware set wins over a write
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ovf_flag_r <= 1'b0;
            mod_flag_r <= 2'h0;
        end else begin
            if (rollover) begin
                ovf_flag_r <= 1'b1;
            end else if (wr_ctrl) begin
                ovf_flag_r <= wbyte[cca_pkg::CCA_CTRL_OVF_FLAG];
            end
            if (ev0) begin
                mod_flag_r[0] <= 1'b1;
            end else if (wr_ctrl) begin
                mod_flag_r[0] <= wbyte[cca_pkg::CCA_CTRL_MOD0_FLAG];
            end
            if (ev1) begin
                mod_flag_r[1] <= 1'b1;
            end else if (wr_ctrl) begin
                mod_flag_r[1] <= wbyte[cca_pkg::CCA_CTRL_MOD1_FLAG];
            end
        end
    end

    logic irq_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (ovf_flag_r & ovf_irq_en_r) |
                     (mod_flag_r[0] & mode0_r.module_event_irq_enable) |
                     (mod_flag_r[1] & mode1_r.module_event_irq_enable);
        end
    end

    assign o_irq = irq_r;

    // ****************************************
    // port pin sharing
    // ****************************************
    logic [2:0] arr_drv;
    logic [2:0] arr_in;
    logic [2:0] arr_val;

    // output use takes the pin even if capture is also enabled
    assign arr_drv = {mode1_r.toggle_on_match_bit | mode1_r.pwm_bit,
                      mode0_r.toggle_on_match_bit | mode0_r.pwm_bit,
                      1'b0};
    assign arr_in = {mode1_r.capture_rising_bit | mode1_r.capture_falling_bit,
                     mode0_r.capture_rising_bit | mode0_r.capture_falling_bit,
                     src_r == cca_pkg::CCA_SRC_EXT};
    assign arr_val = {pin1_out, pin0_out, 1'b0};

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (arr_drv[i]) begin
                o_port_out[i] = arr_val[i];
                o_port_oe[i] = 1'b1;
            end else if (arr_in[i]) begin
                o_port_out[i] = 1'b0;
                o_port_oe[i] = 1'b0;
            end else begin
                o_port_out[i] = i_gpio_out[i];
                o_port_oe[i] = i_gpio_oe[i];
            end
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        rbyte = cca_pkg::CCA_RST_BYTE;
        if (i_avs_address == cca_pkg::CCA_OFF_MODE) begin
            rbyte = {idle_stop_r, 4'h0, src_r, ovf_irq_en_r};
        end else if (i_avs_address == cca_pkg::CCA_OFF_CTRL) begin
            rbyte = {ovf_flag_r, run_r, 4'h0, mod_flag_r};
        end else if (i_avs_address == cca_pkg::CCA_OFF_CNT_LO) begin
            rbyte = count_r[7:0];
        end else if (i_avs_address == cca_pkg::CCA_OFF_CNT_HI) begin
            rbyte = count_r[15:8];
        end else if (i_avs_address == cca_pkg::CCA_OFF_MOD0_MODE) begin
            rbyte = mode0_r;
        end else if (i_avs_address == cca_pkg::CCA_OFF_MOD1_MODE) begin
            rbyte = mode1_r;
        end else if (i_avs_address == cca_pkg::CCA_OFF_CMP0_LO) begin
            rbyte = cmp0[7:0];
        end else if (i_avs_address == cca_pkg::CCA_OFF_CMP0_HI) begin
            rbyte = cmp0[15:8];
        end else if (i_avs_address == cca_pkg::CCA_OFF_CMP1_LO) begin
            rbyte = cmp1[7:0];
        end else if (i_avs_address == cca_pkg::CCA_OFF_CMP1_HI) begin
            rbyte = cmp1[15:8];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_avs_read & (bus_r == cca_pkg::CCA_BUS_IDLE)) begin
            rdata_r <= {24'h00_0000, rbyte};
        end
    end

    assign o_avs_readdata = rdata_r;

endmodule
`default_nettype wire

// ### core/cca_pkg.sv
`default_nettype none
package cca_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [5:0] CCA_OFF_MODE = 6'h00;
    localparam logic [5:0] CCA_OFF_CTRL = 6'h04;
    localparam logic [5:0] CCA_OFF_CNT_LO = 6'h08;
    localparam logic [5:0] CCA_OFF_CNT_HI = 6'h0c;
    localparam logic [5:0] CCA_OFF_MOD0_MODE = 6'h10;
    localparam logic [5:0] CCA_OFF_MOD1_MODE = 6'h14;
    localparam logic [5:0] CCA_OFF_CMP0_LO = 6'h18;
    localparam logic [5:0] CCA_OFF_CMP0_HI = 6'h1c;
    localparam logic [5:0] CCA_OFF_CMP1_LO = 6'h20;
    localparam logic [5:0] CCA_OFF_CMP1_HI = 6'h24;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CCA_MODE_IDLE_STOP = 7;
    localparam int CCA_MODE_SRC_HI = 2;
    localparam int CCA_MODE_SRC_LO = 1;
    localparam int CCA_MODE_OVF_IRQ_EN = 0;
    localparam int CCA_CTRL_OVF_FLAG = 7;
    localparam int CCA_CTRL_RUN = 6;
    localparam int CCA_CTRL_MOD1_FLAG = 1;
    localparam int CCA_CTRL_MOD0_FLAG = 0;

    // ****************************************
    // source select codes
    // ****************************************
    localparam logic [1:0] CCA_SRC_DIV6 = 2'h0;
    localparam logic [1:0] CCA_SRC_DIV2 = 2'h1;
    localparam logic [1:0] CCA_SRC_T0OVF = 2'h2;
    localparam logic [1:0] CCA_SRC_EXT = 2'h3;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0] CCA_RST_BYTE = 8'h00;
    localparam logic [15:0] CCA_RST_WORD = 16'h0000;
    localparam logic [2:0] CCA_DIV6_LAST = 3'h5;
    localparam logic [15:0] CCA_CNT_TOP = 16'hffff;
    localparam logic [7:0] CCA_LO_WRAP = 8'h00;

    // module mode register layout, bit 7 reserved
    typedef struct packed {
        logic rsvd;
        logic compare_enable_bit;
        logic capture_rising_bit;
        logic capture_falling_bit;
        logic flag_on_match_bit;
        logic toggle_on_match_bit;
        logic pwm_bit;
        logic module_event_irq_enable;
    } cca_mode_s;

    localparam cca_mode_s CCA_RST_MODE = '0;

    typedef enum logic [1:0] {
        CCA_BUS_IDLE = 2'b01,
        CCA_BUS_ACK = 2'b10
    } cca_bus_e;

endpackage
`default_nettype wire

// ### core/cca_module.sv
`timescale 1ns/1ns
`default_nettype none
module cca_module (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire cca_pkg::cca_mode_s i_mode,
    input wire logic [15:0] i_count,
    input wire logic i_cnt_step,
    input wire logic i_pin_in,
    input wire logic i_cmp_wr_lo,
    input wire logic i_cmp_wr_hi,
    input wire logic [7:0] i_wdata,
    output logic [15:0] o_cmp,
    output logic o_event,
    output logic o_pin_out
);

    // ****************************************
    // pin synchroniser and edge detect
    // ****************************************
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic rise;
    logic fall;
    logic capture;
    logic match;
    logic [15:0] cmp_r;
    logic out_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= i_pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;
    assign capture = (rise & i_mode.capture_rising_bit) |
                     (fall & i_mode.capture_falling_bit);

    // match only on a fresh count, else a slow time base flags every cycle
    assign match = i_mode.compare_enable_bit & i_cnt_step & (i_count == cmp_r);

    // ****************************************
    // compare / capture register
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cmp_r <= cca_pkg::CCA_RST_WORD;
        end else if (capture) begin
            cmp_r <= i_count;
        end else if (i_mode.pwm_bit & i_cnt_step & (i_count[7:0] == cca_pkg::CCA_LO_WRAP)) begin
            cmp_r[7:0] <= cmp_r[15:8];
        end else begin
            if (i_cmp_wr_lo) begin
                cmp_r[7:0] <= i_wdata;
            end
            if (i_cmp_wr_hi) begin
                cmp_r[15:8] <= i_wdata;
            end
        end
    end

    assign o_cmp = cmp_r;
    assign o_event = capture | (match & i_mode.flag_on_match_bit);

    // ****************************************
    // output pin
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            out_r <= 1'b0;
        end else if (i_mode.pwm_bit & i_mode.compare_enable_bit) begin
            out_r <= (i_count[7:0] >= cmp_r[7:0]);
        end else if (match & i_mode.toggle_on_match_bit) begin
            out_r <= ~out_r;
        end
    end

    assign o_pin_out = out_r;

endmodule
`default_nettype wire

// ### verif/cca_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// bus, pin and interrupt checks
// ****************
module cca_top_checker (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_cpu_idle,
    input wire logic i_timer0_ovf,
    input wire logic [2:0] i_port_in,
    input wire logic [2:0] i_gpio_out,
    input wire logic [2:0] i_gpio_oe,
    input wire logic [2:0] o_port_out,
    input wire logic [2:0] o_port_oe,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic req = i_avs_read | i_avs_write;
    wire logic ack = req & !o_avs_waitrequest;
    chk_one_wait: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest held past one cycle");
    chk_idle_ready: assert property (!req |-> !o_avs_waitrequest)
        else $error("waitrequest high with no request");
    chk_first_wait: assert property ($rose(req) |-> o_avs_waitrequest)
        else $error("request answered without a wait cycle");
    chk_rdata_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
        else $error("read data moved with no read");
    chk_rdata_upper: assert property (o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // pin roles only follow register writes
    chk_oe_steady: assert property (
        $stable(i_gpio_oe) && !$past(i_sys_rst) && !$past(ack) |-> $stable(o_port_oe))
        else $error("pin direction changed without a write");
    chk_gpio_reset: assert property (
        $past(i_sys_rst) |-> o_port_oe == i_gpio_oe &&
        (o_port_out & i_gpio_oe) == (i_gpio_out & i_gpio_oe))
        else $error("pins not plain port after reset");
    chk_irq_fall: assert property (
        $fell(o_irq) |-> $past(i_avs_write && !o_avs_waitrequest, 2))
        else $error("interrupt dropped without a write");
    chk_irq_reset: assert property ($past(i_sys_rst) |-> !o_irq ##1 !o_irq)
        else $error("interrupt right after reset");
endmodule
bind cca_top cca_top_checker u_cca_top_checker (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_cpu_idle(i_cpu_idle), .i_timer0_ovf(i_timer0_ovf), .i_port_in(i_port_in),
    .i_gpio_out(i_gpio_out), .i_gpio_oe(i_gpio_oe), .o_port_out(o_port_out),
    .o_port_oe(o_port_oe), .o_irq(o_irq));
`default_nettype wire

// ### verif/cca_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// port pin partner
// ****************
module cca_pin_model (
    input wire logic i_clk,
    input wire logic [2:0] i_port_out,
    input wire logic [2:0] i_port_oe,
    output logic [2:0] o_port_in
);
    logic [2:0] lvl_r = 3'h0;
    // a driven pin reads back its own level
    assign o_port_in = (i_port_oe & i_port_out) | (~i_port_oe & lvl_r);
    task automatic edge_at(input int p, input logic v);
        @(posedge i_clk);
        lvl_r[p] <= v;
        repeat (4) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ### verif/cca_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cca_top_tb;
    logic i_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic idle = 1'b0;
    logic t0 = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wq;
    logic irq;
    logic o;
    logic [2:0] pin;
    logic [2:0] pout;
    logic [2:0] poe;
    logic [7:0] v;
    int err_total = 0;
    int check_count = 0;
    int i;
    int d;
    cca_top u_cca_top (.i_clk(i_clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_cpu_idle(idle),
        .i_timer0_ovf(t0), .i_port_in(pin), .i_gpio_out(3'h5), .i_gpio_oe(3'h1),
        .o_port_out(pout), .o_port_oe(poe), .o_irq(irq));
    cca_pin_model u_cca_pin_model (.i_clk(i_clk), .i_port_out(pout), .i_port_oe(poe),
        .o_port_in(pin));
    initial forever #5 i_clk = ~i_clk;
    // ****************
    // access tasks
    // ****************
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] dat);
        @(posedge i_clk);
        adr <= a;
        wd <= {24'h0, dat};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge i_clk);
        end while (wq !== 1'b0);
        v = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input string nm, input logic [5:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(nm, {8'h0, e}, {8'h0, v});
    endtask
    task automatic setc(input logic [15:0] c);
        xfer(1'b1, 6'h08, c[7:0]);
        xfer(1'b1, 6'h0c, c[15:8]);
    endtask
    // one-cycle timer 0 pulses, then settle
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge i_clk);
            t0 <= 1'b1;
            @(posedge i_clk);
            t0 <= 1'b0;
        end
        repeat (3) @(posedge i_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge i_clk);
        err_total++;
        complete_run();
    end
    // ****************
    // tests
    // ****************
    initial begin
        repeat (6) @(posedge i_clk);
        rst <= 1'b0;
        xfer(1'b1, 6'h3c, 8'hff);
        for (i = 0; i < 64; i += 4) rc("reset", i[5:0], 8'h00);
        xfer(1'b1, 6'h10, 8'hff);
        rc("mod0 mode", 6'h10, 8'h7f);
        xfer(1'b1, 6'h04, 8'h3c);
        rc("ctrl", 6'h04, 8'h00);
        xfer(1'b1, 6'h10, 8'h00);
        $display("regs done");
        xfer(1'b1, 6'h00, 8'h04);
        xfer(1'b1, 6'h04, 8'h40);
        tick(5);
        xfer(1'b1, 6'h04, 8'h00);
        tick(3);
        rc("t0 count", 6'h08, 8'h05);
        xfer(1'b1, 6'h00, 8'h06);
        @(negedge i_clk);
        chk("pin0 oe", 16'h0, {15'h0, poe[0]});
        xfer(1'b1, 6'h04, 8'h40);
        for (i = 0; i < 4; i++) begin
            u_cca_pin_model.edge_at(0, 1'b1);
            u_cca_pin_model.edge_at(0, 1'b0);
        end
        xfer(1'b1, 6'h04, 8'h00);
        rc("ext count", 6'h08, 8'h09);
        for (i = 0; i < 2; i++) begin
            d = i ? 2 : 6;
            setc(16'h0000);
            xfer(1'b1, 6'h00, {6'h0, i[0], 1'b0});
            xfer(1'b1, 6'h04, 8'h40);
            repeat (120) @(posedge i_clk);
            xfer(1'b1, 6'h04, 8'h00);
            xfer(1'b0, 6'h08, 8'h00);
            chk("div count", 16'h1, {15'h0, v >= 122 / d - 1 && v <= 122 / d + 1});
        end
        setc(16'h0000);
        xfer(1'b1, 6'h00, 8'h84);
        xfer(1'b1, 6'h04, 8'h40);
        idle <= 1'b1;
        tick(3);
        rc("idle stop", 6'h08, 8'h00);
        xfer(1'b1, 6'h00, 8'h04);
        tick(2);
        rc("idle run", 6'h08, 8'h02);
        idle <= 1'b0;
        xfer(1'b1, 6'h04, 8'h00);
        $display("sources done");
        setc(16'hffff);
        xfer(1'b1, 6'h00, 8'h05);
        xfer(1'b1, 6'h04, 8'h40);
        tick(1);
        rc("ovf flag", 6'h04, 8'hc0);
        chk("ovf irq", 16'h1, {15'h0, irq});
        rc("wrap", 6'h0c, 8'h00);
        xfer(1'b1, 6'h00, 8'h04);
        repeat (2) @(posedge i_clk);
        chk("masked irq", 16'h0, {15'h0, irq});
        tick(2);
        rc("ovf held", 6'h04, 8'hc0);
        xfer(1'b1, 6'h04, 8'h00);
        rc("ovf clear", 6'h04, 8'h00);
        $display("overflow done");
        for (i = 0; i < 2; i++) begin
            setc(16'h0000);
            xfer(1'b1, 6'h18, 8'h03);
            xfer(1'b1, 6'h10, i ? 8'h4d : 8'h0d);
            xfer(1'b1, 6'h04, 8'h40);
            o = pout[1];
            tick(3);
            rc("match flag", 6'h04, i ? 8'h41 : 8'h40);
            chk("toggle", {15'h0, o ^ i[0]}, {15'h0, pout[1]});
            chk("match irq", {15'h0, i[0]}, {15'h0, irq});
            xfer(1'b1, 6'h04, 8'h00);
        end
        $display("match done");
        setc(16'h1234);
        for (i = 1; i < 4; i++) begin
            xfer(1'b1, 6'h14, {2'h0, i[1:0], 4'h0});
            @(negedge i_clk);
            chk("pin2 oe", 16'h0, {15'h0, poe[2]});
            xfer(1'b1, 6'h20, 8'h00);
            xfer(1'b1, 6'h24, 8'h00);
            xfer(1'b1, 6'h04, 8'h00);
            u_cca_pin_model.edge_at(2, 1'b1);
            rc("rise flag", 6'h04, {6'h0, i[1], 1'b0});
            rc("rise cap", 6'h24, i[1] ? 8'h12 : 8'h00);
            xfer(1'b1, 6'h04, 8'h00);
            u_cca_pin_model.edge_at(2, 1'b0);
            rc("fall flag", 6'h04, {6'h0, i[0], 1'b0});
            rc("cap low", 6'h20, 8'h34);
            chk("cap irq", 16'h0, {15'h0, irq});
        end
        xfer(1'b1, 6'h14, 8'h00);
        $display("capture done");
        xfer(1'b1, 6'h18, 8'h80);
        xfer(1'b1, 6'h1c, 8'h40);
        xfer(1'b1, 6'h10, 8'h42);
        setc(16'h007e);
        xfer(1'b1, 6'h04, 8'h40);
        tick(1);
        chk("pwm low", 16'h0, {15'h0, pout[1]});
        tick(1);
        chk("pwm high", 16'h1, {15'h0, pout[1]});
        xfer(1'b1, 6'h04, 8'h00);
        setc(16'h00ff);
        xfer(1'b1, 6'h04, 8'h40);
        tick(1);
        rc("pwm reload", 6'h18, 8'h40);
        chk("pwm wrap", 16'h0, {15'h0, pout[1]});
        $display("pwm done");
        complete_run();
    end
endmodule
`default_nettype wire
